// *** core/asp_fifo.sv ***
// small synchronous fifo for conversion samples
`timescale 1ns/1ps
module asp_fifo #(
   parameter int WIDTH = 12,
   parameter int DEPTH = 8
) (
   input wire logic i_clk,
   input wire logic i_resetn,
   input wire logic i_valid,
   output logic o_ready,
   input wire logic [WIDTH-1:0] i_data,
   output logic o_valid,
   input wire logic i_ready,
   output logic [WIDTH-1:0] o_data
);
   localparam int AW = $clog2(DEPTH);
   logic [WIDTH-1:0] mem_r [DEPTH];
   logic [AW-1:0] wp_r;
   logic [AW-1:0] rp_r;
   logic [AW:0] cnt_r;
   logic [AW:0] cnt_nxt;
   logic wr;
   logic rd;
   assign o_valid = (cnt_r != '0);
   assign o_data = mem_r[rp_r];
   assign wr = i_valid && o_ready;
   assign rd = o_valid && i_ready;
   assign cnt_nxt = cnt_r + {{AW{1'b0}}, wr} - {{AW{1'b0}}, rd};
   always_ff @(posedge i_clk) begin
      if (wr) begin
         mem_r[wp_r] <= i_data;
      end
   end
   always_ff @(posedge i_clk or negedge i_resetn) begin
      if (!i_resetn) begin
         wp_r <= '0;
         rp_r <= '0;
         cnt_r <= '0;
         o_ready <= 1'b1;
      end else begin
         if (wr) begin
            wp_r <= (wp_r == AW'(DEPTH - 1)) ? '0 : wp_r + 1'b1;
         end
         if (rd) begin
            rp_r <= (rp_r == AW'(DEPTH - 1)) ? '0 : rp_r + 1'b1;
         end
         cnt_r <= cnt_nxt;
         o_ready <= (cnt_nxt != (AW + 1)'(DEPTH));
      end
   end
endmodule

// *** core/asp_params.svh ***
// constants of the converter serial readout port
`ifndef ASP_PARAMS_SVH
`define ASP_PARAMS_SVH
`define ASP_FRAME_FALLS 5'h10
`define ASP_TRACK_FALLS 5'h0d
`define ASP_LAST_FALLS 5'h0f
`define ASP_CONV_12 5'h10
`define ASP_CONV_10 5'h0e
`define ASP_LEAD_ZEROS 5'h04
`define ASP_RES_W 12
`define ASP_FIFO_DEPTH 8
`endif

// *** core/asp_pkg.sv ***
// types of the converter serial readout port
package asp_pkg;
   typedef enum logic [1:0] {
      ASP_IDLE = 2'b00,
      ASP_CONV = 2'b01,
      ASP_DONE = 2'b10
   } asp_state_type;
endpackage

// *** core/asp_port.sv ***
// serial readout port of a 12-bit or 10-bit converter, sampled on the system clock
`timescale 1ns/1ps
`include "asp_params.svh"
module asp_port
   import asp_pkg::*;
(
   input wire logic i_clk,
   input wire logic i_resetn,
   input wire logic i_cs_n,
   input wire logic i_sclk,
   input wire logic i_res10,
   input wire logic i_smp_valid,
   output logic o_smp_ready,
   input wire logic [`ASP_RES_W-1:0] i_smp_data,
   output logic o_dout,
   output logic o_dout_oe,
   output logic o_hold
);

   // -----------------------------------------------------------------
   // helpers
   // -----------------------------------------------------------------
   // true when the fall counted now brings the count to the target
   function automatic logic reaches(input logic [4:0] count, input logic [4:0] target);
      reaches = (count + 5'h01 == target);
   endfunction

   // edge of a synchronised level between two samples
   function automatic logic went_low(input logic prev, input logic cur);
      went_low = prev && !cur;
   endfunction

   function automatic logic went_high(input logic prev, input logic cur);
      went_high = !prev && cur;
   endfunction

   // -----------------------------------------------------------------
   // input synchronisers
   // -----------------------------------------------------------------
   logic [1:0] cs_s_r;
   logic [1:0] ck_s_r;
   logic cs_d_r;
   logic ck_d_r;
   logic cs_fall;
   logic cs_rise;
   logic ck_fall;
   logic ck_rise;
   logic res10_m_r;
   logic res10_r;
   // detectors start at the idle level, so releasing reset makes no false edge
   always_ff @(posedge i_clk or negedge i_resetn) begin
      if (!i_resetn) begin
         cs_s_r <= 2'b11;
         ck_s_r <= 2'b11;
         cs_d_r <= 1'b1;
         ck_d_r <= 1'b1;
         res10_m_r <= 1'b0;
         res10_r <= 1'b0;
      end else begin
         cs_s_r <= {cs_s_r[0], i_cs_n};
         ck_s_r <= {ck_s_r[0], i_sclk};
         cs_d_r <= cs_s_r[1];
         ck_d_r <= ck_s_r[1];
         // the variant strap is a board pin as well, so it gets two stages
         res10_m_r <= i_res10;
         res10_r <= res10_m_r;
      end
   end
   assign cs_fall = went_low(cs_d_r, cs_s_r[1]);
   assign cs_rise = went_high(cs_d_r, cs_s_r[1]);
   assign ck_fall = went_low(ck_d_r, ck_s_r[1]);
   assign ck_rise = went_high(ck_d_r, ck_s_r[1]);

   // -----------------------------------------------------------------
   // sample buffer: the fifo stands in for the converter core results
   // -----------------------------------------------------------------
   logic smp_valid;
   logic [`ASP_RES_W-1:0] smp_data;
   logic smp_take;
   asp_fifo #(.WIDTH(`ASP_RES_W), .DEPTH(`ASP_FIFO_DEPTH)) u_fifo (
      .i_clk(i_clk),
      .i_resetn(i_resetn),
      .i_valid(i_smp_valid),
      .o_ready(o_smp_ready),
      .i_data(i_smp_data),
      .o_valid(smp_valid),
      .i_ready(smp_take),
      .o_data(smp_data)
   );
   // one word is drained per started frame; an empty buffer gives zeros
   assign smp_take = cs_fall && smp_valid;

   // -----------------------------------------------------------------
   // frame sequencer
   // -----------------------------------------------------------------
   asp_state_type state_r;
   logic [4:0] falls_r;
   logic [15:0] shreg_r;
   logic track_pend_r;
   logic [4:0] conv_need;
   logic [4:0] falls_now;
   logic trail_zero;
   // falls seen so far, counting one that is being detected right now
   assign falls_now = falls_r + {4'h0, ck_fall};
   assign conv_need = res10_r ? `ASP_CONV_10 : `ASP_CONV_12;
   // once the shorter conversion is complete only zeros are left to shift
   assign trail_zero = (falls_now >= conv_need);
   // the serial clock is oversampled, so its edges are counted on i_clk
   always_ff @(posedge i_clk or negedge i_resetn) begin
      if (!i_resetn) begin
         state_r <= ASP_IDLE;
         falls_r <= 5'h00;
      end else if (cs_rise) begin
         state_r <= ASP_IDLE;
         falls_r <= 5'h00;
      end else begin
         // a deselect is handled above, so a cut frame ends from any state
         unique case (state_r)
            ASP_IDLE: begin
               if (cs_fall) begin
                  state_r <= ASP_CONV;
                  falls_r <= 5'h00;
               end
            end
            ASP_CONV: begin
               if (ck_fall) begin
                  falls_r <= falls_now;
                  if (reaches(falls_r, `ASP_FRAME_FALLS)) begin
                     state_r <= ASP_DONE;
                  end
               end
            end
            ASP_DONE: begin
               falls_r <= falls_r;
            end
            default: begin
               state_r <= ASP_IDLE;
               falls_r <= 5'h00;
            end
         endcase
      end
   end

   // result framed as zeros, data msb first, trailing zeros for 10-bit
   always_ff @(posedge i_clk or negedge i_resetn) begin
      if (!i_resetn) begin
         shreg_r <= 16'h0000;
      end else if (cs_fall) begin
         if (!smp_valid) begin
            shreg_r <= 16'h0000;
         end else if (res10_r) begin
            shreg_r <= {4'h0, smp_data[`ASP_RES_W-1:2], 2'b00};
         end else begin
            shreg_r <= {4'h0, smp_data};
         end
      end else if (state_r == ASP_CONV && ck_fall) begin
         shreg_r <= {shreg_r[14:0], 1'b0};
      end
   end

   // a cut frame drops hold at once, so the sampler never stays parked
   // hold from select until the rise after the 13th fall
   always_ff @(posedge i_clk or negedge i_resetn) begin
      if (!i_resetn) begin
         o_hold <= 1'b0;
         track_pend_r <= 1'b0;
      end else if (cs_rise) begin
         o_hold <= 1'b0;
         track_pend_r <= 1'b0;
      end else if (cs_fall) begin
         o_hold <= 1'b1;
         track_pend_r <= 1'b0;
      end else begin
         if (state_r == ASP_CONV && ck_fall && reaches(falls_r, `ASP_TRACK_FALLS)) begin
            track_pend_r <= 1'b1;
         end
         if (track_pend_r && ck_rise) begin
            o_hold <= 1'b0;
            track_pend_r <= 1'b0;
         end
      end
   end

   // -----------------------------------------------------------------
   // output drive
   // -----------------------------------------------------------------
   // enable and data leave flops on the same edge, so no stray bit is shown
   logic oe_nxt;
   logic dout_nxt;
   always_comb begin
      oe_nxt = 1'b0;
      if (cs_rise || cs_s_r[1]) begin
         oe_nxt = 1'b0;
      end else if (cs_fall) begin
         oe_nxt = 1'b1;
      end else if (state_r == ASP_CONV) begin
         oe_nxt = !(ck_fall && reaches(falls_r, `ASP_FRAME_FALLS));
      end
   end
   // a released line shows zero, so only the enable tells a driven bit apart
   always_comb begin
      dout_nxt = 1'b0;
      if (!oe_nxt || cs_fall) begin
         dout_nxt = 1'b0;
      end else if (trail_zero) begin
         dout_nxt = 1'b0;
      end else if (ck_fall) begin
         dout_nxt = shreg_r[14];
      end else begin
         dout_nxt = shreg_r[15];
      end
   end
   always_ff @(posedge i_clk or negedge i_resetn) begin
      if (!i_resetn) begin
         o_dout_oe <= 1'b0;
         o_dout <= 1'b0;
      end else begin
         o_dout_oe <= oe_nxt;
         o_dout <= dout_nxt;
      end
   end
endmodule

// *** verif/asp_host.sv ***
// host model: frames with select, clocks the port and shifts the result in
`timescale 1ns/1ps
module asp_host (
   input wire logic i_clk,
   input wire logic i_dout,
   input wire logic i_dout_oe,
   output logic o_cs_n,
   output logic o_sclk,
   output logic [16:0] o_word,
   output logic o_done
);
   initial begin
      o_cs_n = 1;
      o_sclk = 1;
      o_word = 0;
      o_done = 0;
   end
   // whole system clocks per half period keeps sampling equidistant
   task automatic half;
      repeat (8) @(posedge i_clk);
      #1;
   endtask
   // late: select falls just after a clock fall and bits are read at rises
   task automatic run(input int n, input bit late);
      half;
      if (late) begin
         o_sclk = 0;
         @(posedge i_clk);
         #1;
      end
      o_cs_n = 0;
      for (int k = 0; k < n; k++) begin
         half;
         o_word = {o_word[15:0], i_dout};
         o_sclk = late;
         half;
         o_sclk = !late;
      end
      half;
      o_word = {o_word[15:0], i_dout_oe};
      o_sclk = 1;
      o_cs_n = 1;
      if (n == 16) begin
         o_done = 1;
         @(posedge i_clk);
         #1 o_done = 0;
      end
   endtask
endmodule

// *** verif/asp_port_props.sv ***
// concurrent checks on the ports of the serial readout port
`timescale 1ns/1ps
module asp_port_props (
   input wire logic i_clk,
   input wire logic i_resetn,
   input wire logic i_cs_n,
   input wire logic i_sclk,
   input wire logic i_smp_valid,
   input wire logic o_smp_ready,
   input wire logic o_dout,
   input wire logic o_dout_oe,
   input wire logic o_hold
);
   default clocking cb @(posedge i_clk);
   endclocking
   default disable iff (!i_resetn);
   a_idle_no_drive: assert property (i_cs_n [*6] |-> !o_dout_oe)
      else $error("output driven while deselected");
   a_select_drives: assert property ($fell(i_cs_n) |-> ##[3:5] (o_dout_oe && o_hold && !o_dout))
      else $error("select did not hold and drive a zero");
   a_abort_release: assert property ($rose(i_cs_n) |-> ##[3:5] !o_dout_oe)
      else $error("deselect did not release output");
   a_undriven_low: assert property (!o_dout_oe |-> !o_dout)
      else $error("data high while released");
   a_hold_with_oe: assert property ($rose(o_dout_oe) |-> o_hold)
      else $error("driving without hold");
   // bits move only a few cycles after a serial clock fall
   a_bit_on_fall: assert property (o_dout_oe && $past(o_dout_oe) && $changed(o_dout)
      |-> $past(i_sclk, 6) && !$past(i_sclk, 3))
      else $error("data changed away from a clock fall");
   a_track_on_rise: assert property ($fell(o_hold) |-> $past(i_sclk, 3) || $past(i_cs_n, 3))
      else $error("hold dropped without clock rise");
   a_full_by_write: assert property ($fell(o_smp_ready) |-> $past(i_smp_valid))
      else $error("fifo filled without a write");
   c_abort: cover property ($rose(i_cs_n) && o_dout_oe);
   c_full: cover property (!o_smp_ready);
   c_track: cover property ($fell(o_hold));
endmodule
bind asp_port asp_port_props u_asp_port_props (.i_clk(i_clk), .i_resetn(i_resetn), .i_cs_n(i_cs_n),
   .i_sclk(i_sclk), .i_smp_valid(i_smp_valid), .o_smp_ready(o_smp_ready), .o_dout(o_dout),
   .o_dout_oe(o_dout_oe), .o_hold(o_hold));

// *** verif/testbench.sv ***
// self-checking bench for the serial readout port
`timescale 1ns/1ps
`include "asp_params.svh"
module testbench;
   `define CHK(a, b) begin n_compared++; if ((a) !== (b)) begin failures++; $display("FAIL %0t %h %h", $time, a, b); end end
   logic i_clk = 0;
   logic i_resetn = 0;
   logic i_res10 = 0;
   logic i_smp_valid = 0;
   logic [`ASP_RES_W-1:0] i_smp_data = 0;
   logic cs_n, sclk, o_smp_ready, o_dout, o_dout_oe, o_hold, done;
   logic [16:0] word;
   logic [16:0] q[$];
   logic [16:0] exp_word;
   int failures = 0, n_compared = 0, cyc = 0, i;
   integer seed = 15858;
   always #2.5 i_clk = ~i_clk;
   asp_port u_asp_port (.i_clk(i_clk), .i_resetn(i_resetn), .i_cs_n(cs_n), .i_sclk(sclk), .i_res10(i_res10),
      .i_smp_valid(i_smp_valid), .o_smp_ready(o_smp_ready), .i_smp_data(i_smp_data), .o_dout(o_dout),
      .o_dout_oe(o_dout_oe), .o_hold(o_hold));
   asp_host u_asp_host (.i_clk(i_clk), .i_dout(o_dout), .i_dout_oe(o_dout_oe), .o_cs_n(cs_n), .o_sclk(sclk),
      .o_word(word), .o_done(done));
   task stop_test;
      $display("failures %0d compared %0d", failures, n_compared);
      if (failures == 0 && n_compared > 0) $display("Finished cleanly");
      else $display("Finished with errors");
      $finish;
   endtask
   always @(posedge i_clk) begin
      cyc++;
      if (cyc == 8000) begin
         failures++;
         stop_test;
      end
   end
   // last bit seen by the host is the enable just before deselect
   always @(posedge i_clk) begin
      if (done) begin
         exp_word = q.pop_front();
         `CHK(word, exp_word)
         `CHK(o_hold, 1'b0)
      end
   end
   initial begin
      repeat (16) @(posedge i_clk);
      #1 i_resetn = 1;
      repeat (4) @(posedge i_clk);
      u_asp_host.run(8, 1'b0);
      for (i = 0; i < 9; i++) begin
         @(posedge i_clk);
         #1 i_smp_data = 12'($random(seed));
         i_smp_valid = 1;
         `CHK(o_smp_ready, i < 8)
         if (i < 8) q.push_back(i[0] ? {4'h0, i_smp_data[11:2], 3'b000} : {4'h0, i_smp_data, 1'b0});
      end
      @(posedge i_clk);
      #1 i_smp_valid = 0;
      for (i = 0; i < 9; i++) begin
         i_res10 = i[0];
         if (i == 8) q.push_back(17'h0_0000);
         u_asp_host.run(16, i == 2 || i == 5);
      end
      repeat (20) @(posedge i_clk);
      `CHK(q.size(), 0)
      stop_test;
   end
endmodule
